// ==== include/hps_map.vh ====
// Purpose: constants for the host port select, decode and interrupt block
// Assumes: one 200 MHz clock; host pins already synchronous to it
// Notes: numbers shared by the top module and its alarm memory
// Functional notes
// - Host select low enables the port; activity is ignored while it is high.
// - Interrupt output goes low whenever any alarm status changes.
// - Reading the status registers releases the interrupt output high.
// - Interrupts only while global enable is one; otherwise output stays high.
// - In synchronous mode accesses are timed by the host processor clock.
// - Low eight address bits are the internal register address.
// - Upper code 000 selects self; 001, 010, 011 assert companion selects 1-3.
// - Upper code 111 asserts all five companion selects and self.
// - Five companion chip select outputs are provided.
// - Reset held low over 10 us returns all registers to defaults.
// - Type select: 000 latch style, 001 strobe style, 111 synchronous.
`ifndef HPS_MAP_VH
`define HPS_MAP_VH
`define HPS_ADDR_W        11
`define HPS_REG_W         8
`define HPS_DATA_W        8
`define HPS_NUM_COMP      5
`define HPS_UP_SELF       3'h0
`define HPS_UP_RSVD       3'h6
`define HPS_UP_ALL        3'h7
`define HPS_TYPE_LATCH    3'h0
`define HPS_TYPE_STROBE   3'h1
`define HPS_TYPE_SYNC     3'h7
`define HPS_ALARM_DEPTH   16
`define HPS_ALARM_AW      4
`define HPS_STATUS_FIRST  8'hE0
`define HPS_CTRL_ADDR     8'hFF
`define HPS_GIE_BIT       0
`define HPS_CTRL_RESET    8'h00
`define HPS_RESET_US      10
`define HPS_CLK_MHZ       200
`define HPS_RESET_CYCLES  (`HPS_RESET_US * `HPS_CLK_MHZ)
`endif

// ==== rtl/hps_alarm_mem.v ====
// Purpose: small status memory holding sticky alarm-change bits per register
// Assumes: single clock, one write port, registered read data
// Notes: set bits win over a read-clear of the same word
`timescale 1ns/1ps
`include "hps_map.vh"
module hps_alarm_mem (
	input  wire                          clk_i,
	input  wire                          resetn_i,
	input  wire                          ce_i,
	input  wire [`HPS_ALARM_AW-1:0]      raddr_i,
	input  wire                          rclr_i,
	input  wire [`HPS_ALARM_AW-1:0]      saddr_i,
	input  wire [`HPS_DATA_W-1:0]        sbits_i,
	output reg  [`HPS_DATA_W-1:0]        rdata_o,
	output reg                           any_o
);
	reg [`HPS_DATA_W-1:0] mem [0:`HPS_ALARM_DEPTH-1];
	wire [`HPS_ALARM_DEPTH-1:0] nz;
	integer i;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (i = 0; i < `HPS_ALARM_DEPTH; i = i + 1) begin
				mem[i] <= 8'h00;
			end
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			rdata_o <= mem[raddr_i];
			for (i = 0; i < `HPS_ALARM_DEPTH; i = i + 1) begin
				if (rclr_i && (raddr_i == i[`HPS_ALARM_AW-1:0]))
					mem[i] <= (saddr_i == i[`HPS_ALARM_AW-1:0]) ? sbits_i : 8'h00;
				else if (saddr_i == i[`HPS_ALARM_AW-1:0])
					mem[i] <= mem[i] | sbits_i;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `HPS_ALARM_DEPTH; g = g + 1) begin : g_nz
			assign nz[g] = |mem[g];
		end
	endgenerate

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			any_o <= 1'b0;
		end else if (ce_i) begin
			any_o <= |nz;
		end
	end
endmodule // hps_alarm_mem

// ==== rtl/hps_top.v ====
// Purpose: host port select decode, companion chip selects and interrupt output
// Assumes: host pins sampled on clk_i; strobe timing handled elsewhere
// Notes: all outputs registered, so decode appears one clock after the pins in strobe mode, two in latch mode, one after the host clock latch in sync mode
`timescale 1ns/1ps
`include "hps_map.vh"
module hps_top (
	input  wire                     clk_i,
	input  wire                     resetn_i,
	input  wire                     ce_i,
	input  wire                     host_sel_n_i,
	input  wire [`HPS_ADDR_W-1:0]   addr_i,
	input  wire                     wr_stb_i,
	input  wire                     rd_stb_i,
	input  wire [`HPS_DATA_W-1:0]   wdata_i,
	input  wire                     addr_latch_or_xfer_start_i,
	input  wire                     host_clk_i,
	input  wire [2:0]               host_type_sel_i,
	input  wire [`HPS_ALARM_AW-1:0] alarm_idx_i,
	input  wire [`HPS_DATA_W-1:0]   alarm_state_i,
	output reg                      self_sel_o,
	output reg  [`HPS_REG_W-1:0]    reg_addr_o,
	output reg                      reg_wr_o,
	output reg                      reg_rd_o,
	output reg  [`HPS_DATA_W-1:0]   reg_wdata_o,
	output reg  [`HPS_NUM_COMP-1:0] companion_sel_n_o,
	output reg                      ready_or_xfer_ack_o,
	output reg                      irq_n_o,
	output reg                      global_irq_enable_o,
	output reg  [2:0]               mode_o
);
	localparam ST_IDLE = 3'b001;
	localparam ST_ACC  = 3'b010;
	localparam ST_DONE = 3'b100;
	localparam [`HPS_DATA_W-1:0] CTRL_RESET = `HPS_CTRL_RESET;

	reg  [2:0]               state;
	reg  [2:0]               next_state;
	reg  [`HPS_REG_W-1:0]    latched_addr;
	reg  [2:0]               latched_up;
	reg                      host_clk_d;
	reg  [`HPS_DATA_W-1:0]   alarm_prev [0:`HPS_ALARM_DEPTH-1];
	wire [`HPS_DATA_W-1:0]   alarm_change;
	wire                     any_alarm;
	wire                     sync_mode;
	wire                     use_latch;
	wire                     access_tick;
	wire [2:0]               upper;
	wire [`HPS_REG_W-1:0]    low_addr;
	wire                     self_hit;
	wire                     status_rd;
	integer i;

	// Upper code to companion select vector, active high
	function [`HPS_NUM_COMP-1:0] comp_decode;
		input [2:0] code;
		begin
			case (code)
			3'h1:        comp_decode = 5'h01;
			3'h2:        comp_decode = 5'h02;
			3'h3:        comp_decode = 5'h04;
			3'h4:        comp_decode = 5'h08;
			3'h5:        comp_decode = 5'h10;
			`HPS_UP_ALL: comp_decode = 5'h1F;
			default:     comp_decode = 5'h00;
			endcase
		end
	endfunction

	function is_self;
		input [2:0] code;
		begin
			is_self = (code == `HPS_UP_SELF) || (code == `HPS_UP_ALL);
		end
	endfunction

	assign sync_mode = (mode_o == `HPS_TYPE_SYNC);
	assign use_latch = (mode_o == `HPS_TYPE_LATCH) || sync_mode;
	// Sync mode moves only on a rising edge of the host clock
	assign access_tick = sync_mode ? (host_clk_i && !host_clk_d) : 1'b1;
	assign upper = use_latch ? latched_up : addr_i[10:8];
	assign low_addr = use_latch ? latched_addr : addr_i[`HPS_REG_W-1:0];
	assign self_hit = !host_sel_n_i && is_self(upper);
	// Status words sit at the top of the map; a read clears the word it addresses
	assign status_rd = self_hit && rd_stb_i && (state == ST_ACC) && access_tick
		&& ({low_addr[7:4], 4'h0} == `HPS_STATUS_FIRST);

	// Alarm change detection, one word per status register
	assign alarm_change = alarm_state_i ^ alarm_prev[alarm_idx_i];

	// Previous levels are kept, so a clearing alarm counts as a change as well as a rising one

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (i = 0; i < `HPS_ALARM_DEPTH; i = i + 1) begin
				alarm_prev[i] <= 8'h00;
			end
		end else if (ce_i) begin
			alarm_prev[alarm_idx_i] <= alarm_state_i;
		end
	end

	// Status read data stays inside: the data bus itself is handled elsewhere
	hps_alarm_mem u_mem (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.ce_i     (ce_i),
		.raddr_i  (low_addr[`HPS_ALARM_AW-1:0]),
		.rclr_i   (status_rd),
		.saddr_i  (alarm_idx_i),
		.sbits_i  (alarm_change),
		.rdata_o  (),
		.any_o    (any_alarm)
	);

	// Acknowledge holds until the strobe drops, so one held strobe is one access
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (!host_sel_n_i && access_tick)
				next_state = ST_ACC;
		end
		ST_ACC: begin
			if (host_sel_n_i)
				next_state = ST_IDLE;
			else if (access_tick && (wr_stb_i || rd_stb_i))
				next_state = ST_DONE;
		end
		ST_DONE: begin
			if (host_sel_n_i || !(wr_stb_i || rd_stb_i))
				next_state = ST_IDLE;
		end
		default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state               <= ST_IDLE;
			latched_addr        <= 8'h00;
			latched_up          <= 3'h0;
			host_clk_d          <= 1'b0;
			mode_o              <= `HPS_TYPE_LATCH;
			self_sel_o          <= 1'b0;
			reg_addr_o          <= 8'h00;
			reg_wr_o            <= 1'b0;
			reg_rd_o            <= 1'b0;
			reg_wdata_o         <= 8'h00;
			companion_sel_n_o   <= 5'h1F;
			ready_or_xfer_ack_o <= 1'b0;
			irq_n_o             <= 1'b1;
			global_irq_enable_o <= CTRL_RESET[`HPS_GIE_BIT];
		end else if (ce_i) begin
			state      <= next_state;
			host_clk_d <= host_clk_i;
			// Type is only changed while the port is idle to avoid a torn access
			if (host_sel_n_i)
				mode_o <= host_type_sel_i;
			// Latched modes decode the captured copy; the direct mode ignores it
			if (!host_sel_n_i && addr_latch_or_xfer_start_i && access_tick) begin
				latched_addr <= addr_i[`HPS_REG_W-1:0];
				latched_up   <= addr_i[10:8];
			end
			self_sel_o <= self_hit;
			reg_addr_o <= low_addr;
			// A deselected host forces every companion select inactive
			if (host_sel_n_i)
				companion_sel_n_o <= 5'h1F;
			else
				companion_sel_n_o <= ~comp_decode(upper);
			// Pulses last one cycle whatever the strobe length
			reg_wr_o <= self_hit && wr_stb_i && (state == ST_ACC) && access_tick;
			reg_rd_o <= self_hit && rd_stb_i && (state == ST_ACC) && access_tick;
			reg_wdata_o <= wdata_i;
			ready_or_xfer_ack_o <= self_hit && (state == ST_DONE);
			// Only the enable bit of the control word is stored
			if (self_hit && wr_stb_i && (state == ST_ACC) && access_tick
				&& (low_addr == `HPS_CTRL_ADDR))
				global_irq_enable_o <= wdata_i[`HPS_GIE_BIT];
			// Follows the registered summary, so it lags an alarm change by three cycles
			irq_n_o <= ~(global_irq_enable_o && any_alarm);
		end
	end
endmodule // hps_top

// ==== testbench/hps_top_asserts.sv ====
// Purpose: bound checks on select decode, strobes and interrupt gating
// Assumes: one clock; ce_i high; decode judged only on an address held with latch high
// Notes: reg_addr_o is compared with the address one clock earlier
`timescale 1ns/1ps
module hps_top_asserts (
	input wire        clk_i,
	input wire        resetn_i,
	input wire        host_sel_n_i,
	input wire [10:0] addr_i,
	input wire        wr_stb_i,
	input wire        rd_stb_i,
	input wire [7:0]  wdata_i,
	input wire        addr_latch_or_xfer_start_i,
	input wire        self_sel_o,
	input wire [7:0]  reg_addr_o,
	input wire        reg_wr_o,
	input wire        reg_rd_o,
	input wire [7:0]  reg_wdata_o,
	input wire [4:0]  companion_sel_n_o,
	input wire        irq_n_o,
	input wire        global_irq_enable_o
);
	reg  [10:0] addr_q;
	wire        hold;
	wire [2:0]  code;
	always @(posedge clk_i) begin
		addr_q <= addr_i;
	end
	// Latched modes decode the captured address, so only a steady latched one is judged
	assign hold = !host_sel_n_i && addr_latch_or_xfer_start_i && addr_i == addr_q;
	assign code = addr_i[10:8];
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	AST_UNSEL: assert property (host_sel_n_i [*2] |=> !reg_wr_o && !reg_rd_o
		&& !self_sel_o && companion_sel_n_o == 5'h1F) else $error("active while deselected");
	AST_COMP: assert property ((hold && code >= 3'h1 && code <= 3'h5) [*2] |=>
		companion_sel_n_o == ~(5'h01 << (addr_q[10:8] - 3'h1)) && !self_sel_o) else $error("comp");
	AST_SELF: assert property ((hold && code == 3'h0) [*2] |=> self_sel_o
		&& companion_sel_n_o == 5'h1F) else $error("self decode");
	AST_ALL: assert property ((hold && code == 3'h7) [*2] |=> self_sel_o
		&& companion_sel_n_o == 5'h00) else $error("all decode");
	AST_RSVD: assert property ((hold && code == 3'h6) [*2] |=> !self_sel_o
		&& companion_sel_n_o == 5'h1F) else $error("reserved decode");
	AST_WR: assert property (reg_wr_o |-> $past(wr_stb_i) && !$past(host_sel_n_i)
		&& !$past(reg_wr_o)) else $error("write pulse");
	AST_RD: assert property (reg_rd_o |-> $past(rd_stb_i) && !$past(host_sel_n_i)
		&& !$past(reg_rd_o)) else $error("read pulse");
	AST_WDATA: assert property (reg_wr_o |-> reg_wdata_o == $past(wdata_i))
		else $error("write data");
	AST_ADDR: assert property (reg_wr_o || reg_rd_o |-> reg_addr_o == addr_q[7:0])
		else $error("register address");
	AST_GATE: assert property (!global_irq_enable_o [*3] |-> irq_n_o)
		else $error("interrupt while disabled");
endmodule // hps_top_asserts
bind hps_top hps_top_asserts hps_top_asserts_inst (.clk_i(clk_i), .resetn_i(resetn_i),
	.host_sel_n_i(host_sel_n_i), .addr_i(addr_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
	.wdata_i(wdata_i), .addr_latch_or_xfer_start_i(addr_latch_or_xfer_start_i),
	.self_sel_o(self_sel_o), .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o),
	.reg_rd_o(reg_rd_o), .reg_wdata_o(reg_wdata_o), .companion_sel_n_o(companion_sel_n_o),
	.irq_n_o(irq_n_o), .global_irq_enable_o(global_irq_enable_o));

// ==== testbench/hps_host_model.sv ====
// Purpose: host processor model driving select, address, strobes and processor clock
// Assumes: requests change 1 ns after a rising bench clock edge
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module hps_host_model (
	input  wire        clk_i,
	input  wire        ack_i,
	output reg         sel_n_o,
	output reg  [10:0] addr_o,
	output reg         wr_o,
	output reg         rd_o,
	output reg  [7:0]  wdata_o,
	output reg         ale_o,
	output reg         host_clk_o
);
	integer n;
	initial {sel_n_o, ale_o, wr_o, rd_o, host_clk_o, addr_o, wdata_o} = 24'h800000;
	// Free running, so sync transfers wait for its next rising edge
	always #10 host_clk_o = ~host_clk_o;
	task present(input [10:0] a);
		@(posedge clk_i);
		#1;
		sel_n_o = 1'b0;
		addr_o = a;
		ale_o = 1'b1;
	endtask
	task idle;
		{sel_n_o, ale_o, wr_o, rd_o} = 4'h8;
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
	endtask
	task access(input [10:0] a, input w, input [7:0] d, output reg ok);
		present(a);
		wdata_o = d;
		// Start held over a whole processor clock period so sync mode always sees it
		repeat (4) @(posedge clk_i);
		#1;
		ale_o = 1'b0;
		wr_o = w;
		rd_o = !w;
		ok = 1'b0;
		for (n = 0; n < 40 && !ok; n = n + 1) begin
			@(posedge clk_i);
			ok = ack_i === 1'b1;
		end
		#1;
		idle();
	endtask
endmodule // hps_host_model

// ==== testbench/test_host_port_select_decode.sv ====
// Purpose: self-checking bench for select decode, transfers and interrupt
// Assumes: 200 MHz clock; ce_i tied high
// Notes: decode expectations come from the address code table
`timescale 1ns/1ps
module test_host_port_select_decode;
	reg         clk_i = 1'b0;
	reg         resetn_i = 1'b0;
	reg  [2:0]  host_type_sel_i = 3'h0;
	reg  [3:0]  alarm_idx_i = 4'h3;
	reg  [7:0]  alarm_state_i = 8'h00;
	wire        ce_i = 1'b1;
	wire        host_sel_n_i, wr_stb_i, rd_stb_i, addr_latch_or_xfer_start_i, host_clk_i;
	wire        self_sel_o, reg_wr_o, reg_rd_o, ready_or_xfer_ack_o, irq_n_o, global_irq_enable_o;
	wire [10:0] addr_i;
	wire [7:0]  wdata_i, reg_addr_o, reg_wdata_o;
	wire [4:0]  companion_sel_n_o;
	wire [2:0]  mode_o;
	integer     checks = 0;
	integer     n_errors = 0;
	always #2.5 clk_i = ~clk_i;
	hps_host_model hps_host_model_inst (.clk_i(clk_i), .ack_i(ready_or_xfer_ack_o),
		.sel_n_o(host_sel_n_i), .addr_o(addr_i), .wr_o(wr_stb_i), .rd_o(rd_stb_i),
		.wdata_o(wdata_i), .ale_o(addr_latch_or_xfer_start_i), .host_clk_o(host_clk_i));
	hps_top hps_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
		.host_sel_n_i(host_sel_n_i), .addr_i(addr_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
		.wdata_i(wdata_i), .addr_latch_or_xfer_start_i(addr_latch_or_xfer_start_i),
		.host_clk_i(host_clk_i), .host_type_sel_i(host_type_sel_i), .alarm_idx_i(alarm_idx_i),
		.alarm_state_i(alarm_state_i), .self_sel_o(self_sel_o), .reg_addr_o(reg_addr_o),
		.reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .reg_wdata_o(reg_wdata_o),
		.companion_sel_n_o(companion_sel_n_o), .ready_or_xfer_ack_o(ready_or_xfer_ack_o),
		.irq_n_o(irq_n_o), .global_irq_enable_o(global_irq_enable_o), .mode_o(mode_o));
	task check(input ok, input string m);
		checks = checks + 1;
		if (!ok) begin
			$display("[FAIL] %0t %s", $time, m);
			n_errors = n_errors + 1;
		end
	endtask
	task wrap_up;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task step(input integer k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task acc(input [10:0] a, input w, input [7:0] d);
		reg ok;
		hps_host_model_inst.access(a, w, d, ok);
		check(ok, "no acknowledge");
		if (!ok)
			wrap_up;
	endtask
	task wait_irq(input lvl);
		integer i;
		for (i = 0; i < 12 && irq_n_o !== lvl; i = i + 1)
			step(1);
		check(irq_n_o === lvl, "interrupt level");
		if (irq_n_o !== lvl)
			wrap_up;
	endtask
	task t_decode;
		integer c;
		reg [4:0] e;
		for (c = 0; c < 8; c = c + 1) begin
			e = c == 7 ? 5'h00 : (c >= 1 && c <= 5) ? ~(5'h01 << (c - 1)) : 5'h1F;
			hps_host_model_inst.present({c[2:0], 8'h5A});
			step(3);
			check(companion_sel_n_o === e, "companion decode");
			check(self_sel_o === (c == 0 || c == 7), "self decode");
			hps_host_model_inst.idle();
		end
		step(2);
		check(companion_sel_n_o === 5'h1F && self_sel_o === 1'b0, "idle selects");
	endtask
	task t_modes;
		integer k;
		reg [2:0] m;
		for (k = 0; k < 3; k = k + 1) begin
			m = k == 0 ? 3'h1 : k == 1 ? 3'h7 : 3'h0;
			host_type_sel_i = m;
			step(3);
			check(mode_o === m, "mode select");
			acc(11'h0FF, 1'b1, {7'h00, k[0]});
			check(global_irq_enable_o === k[0], "enable write");
		end
	endtask
	task t_irq;
		alarm_state_i = 8'h04;
		step(6);
		check(irq_n_o === 1'b1, "interrupt while disabled");
		acc(11'h0FF, 1'b1, 8'h01);
		wait_irq(1'b0);
		acc(11'h0E3, 1'b0, 8'h00);
		wait_irq(1'b1);
		alarm_state_i = 8'h00;
		wait_irq(1'b0);
		acc(11'h7E3, 1'b0, 8'h00);
		wait_irq(1'b1);
	endtask
	initial begin
		step(12);
		resetn_i = 1'b1;
		t_decode;
		t_modes;
		t_irq;
		resetn_i = 1'b0;
		step(4);
		check(global_irq_enable_o === 1'b0 && companion_sel_n_o === 5'h1F, "reset");
		resetn_i = 1'b1;
		step(2);
		wrap_up;
	end
	initial begin
		#100000;
		check(1'b0, "run timeout");
		wrap_up;
	end
endmodule // test_host_port_select_decode
